// ==== core/csb_map.vh ====
// Constants for the sample capture buffer: offsets, fields, widths, codes
`ifndef CSB_MAP_VH
`define CSB_MAP_VH

// Register bus geometry
`define CSB_ADDR_W        12
`define CSB_BUS_W         32
`define CSB_STRB_W        4
`define CSB_OFF_CTRL      12'h000
`define CSB_OFF_STATUS    12'h004
`define CSB_OFF_PERIOD    12'h008
`define CSB_RESP_OKAY     2'h0
`define CSB_RESP_SLVERR   2'h2

// Control register layout and reset value
`define CSB_CTRL_W        10
`define CSB_CTRL_RST      10'h0E8
`define CSB_B_CHIP_SLEEP  0
`define CSB_B_CONV_SLEEP  1
`define CSB_B_AUTO_HALT   2
`define CSB_B_BUF_EN      3
`define CSB_B_PLL_EN      4
`define CSB_B_OUT_EN      5
`define CSB_F_DEPTH_LO    6
`define CSB_F_DEPTH_HI    7
`define CSB_F_FACTOR_LO   8
`define CSB_F_FACTOR_HI   9
`define CSB_BYTE0_HI      7
`define CSB_CTRL_HI       9

// Status register layout
`define CSB_S_EMPTY       0
`define CSB_S_FULL        1
`define CSB_S_ASLEEP      2
`define CSB_S_COUNT_LO    16

// Buffer geometry and selectable depths
`define CSB_DATA_W        8
`define CSB_RAM_AW        10
`define CSB_RAM_WORDS     1024
`define CSB_PTR_W         11
`define CSB_PTR_ONE       11'h001
`define CSB_PTR_ZERO      11'h000
`define CSB_DEPTH_SEL0    11'h080
`define CSB_DEPTH_SEL1    11'h100
`define CSB_DEPTH_SEL2    11'h200
`define CSB_DEPTH_SEL3    11'h400

// Clock multiplier factors and period counter
`define CSB_FAC_W         3
`define CSB_FACTOR_SEL0   3'h2
`define CSB_FACTOR_SEL1   3'h3
`define CSB_FACTOR_SEL2   3'h4
`define CSB_FACTOR_SEL3   3'h5
`define CSB_CNT_W         16
`define CSB_CNT_ZERO      16'h0000
`define CSB_CNT_ONE       16'h0001
`define CSB_CNT_MAX       16'hFFFF

// Synchronised pin vector positions
`define CSB_PIN_W         12
`define CSB_PIN_REF       0
`define CSB_PIN_WEN       1
`define CSB_PIN_DCLK      2
`define CSB_PIN_DEN       3
`define CSB_PIN_DATA_LO   4

`endif

// ==== core/csb_byte_ram.v ====
// Byte storage array of the capture buffer
`timescale 1ns/1ns
`default_nettype none
`include "csb_map.vh"

module csb_byte_ram (
  input  wire                       core_clk,
  input  wire                       wr_en,
  input  wire [`CSB_RAM_AW-1:0]     wr_addr,
  input  wire [`CSB_DATA_W-1:0]     wr_data,
  input  wire [`CSB_RAM_AW-1:0]     rd_addr,
  output wire [`CSB_DATA_W-1:0]     rd_data
);

  reg [`CSB_DATA_W-1:0] mem [0:`CSB_RAM_WORDS-1];

  // Write port, one byte per enabled edge
  always @(posedge core_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Read port is asynchronous; caller registers it
  assign rd_data = mem[rd_addr];

endmodule
`default_nettype wire

// ==== core/csb_capture_buffer.v ====
// Sample capture buffer with clock multiplier, drain port and AXI4-Lite control
//
// How it works
// - Chip sleep high stops sampling and draining; register bus stays live
// - Entering chip sleep discards bytes, holds output
// - Converter sleep stops sampling, buffer stays readable
// - Bypass: sample on input clock rising edge
// - Multiplier on: input clock is reference, multiplied
// - Buffer enabled: bytes drained by drain clock
// - Data and empty flag change on drain edge
// - Write enable high stores byte per sample
// - Drain enable high reads byte per drain edge
// - Reset returns all control logic to initial
// - Output enable high drives data pins
// - Output enable low floats data pins
// - Selectable depth, at most 1024 bytes
// - Samples are 8-bit straight binary bytes
// - Empty flag high when nothing unread
// - Full flag high at selected depth
// - Auto halt stops writes when full
// - Two-bit select sets multiplier ratio
//
// Implementation choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
`include "csb_map.vh"

module csb_capture_buffer (
  input  wire                       core_clk,
  input  wire                       rst,
  input  wire                       s_axi_awvalid,
  output wire                       s_axi_awready,
  input  wire [`CSB_ADDR_W-1:0]     s_axi_awaddr,
  input  wire                       s_axi_wvalid,
  output wire                       s_axi_wready,
  input  wire [`CSB_BUS_W-1:0]      s_axi_wdata,
  input  wire [`CSB_STRB_W-1:0]     s_axi_wstrb,
  output wire                       s_axi_bvalid,
  input  wire                       s_axi_bready,
  output wire [1:0]                 s_axi_bresp,
  input  wire                       s_axi_arvalid,
  output wire                       s_axi_arready,
  input  wire [`CSB_ADDR_W-1:0]     s_axi_araddr,
  output wire                       s_axi_rvalid,
  input  wire                       s_axi_rready,
  output wire [`CSB_BUS_W-1:0]      s_axi_rdata,
  output wire [1:0]                 s_axi_rresp,
  input  wire [`CSB_DATA_W-1:0]     sample_data,
  input  wire                       sample_ref_clk,
  input  wire                       capture_wen,
  input  wire                       drain_clk,
  input  wire                       drain_en,
  output wire [`CSB_DATA_W-1:0]     data_out,
  output wire                       data_oe_n,
  output wire                       empty_flag,
  output wire                       full_flag
);

  // Depth decode from the two-bit select
  function [`CSB_PTR_W-1:0] depth_of;
    input [1:0] sel;
    begin
      case (sel)
        2'h0:    depth_of = `CSB_DEPTH_SEL0;
        2'h1:    depth_of = `CSB_DEPTH_SEL1;
        2'h2:    depth_of = `CSB_DEPTH_SEL2;
        default: depth_of = `CSB_DEPTH_SEL3;
      endcase
    end
  endfunction

  // Multiplier ratio from the two-bit select
  function [`CSB_FAC_W-1:0] factor_of;
    input [1:0] sel;
    begin
      case (sel)
        2'h0:    factor_of = `CSB_FACTOR_SEL0;
        2'h1:    factor_of = `CSB_FACTOR_SEL1;
        2'h2:    factor_of = `CSB_FACTOR_SEL2;
        default: factor_of = `CSB_FACTOR_SEL3;
      endcase
    end
  endfunction

  // Address decode shared by both bus directions
  function mapped;
    input [`CSB_ADDR_W-1:0] addr;
    begin
      mapped = (addr == `CSB_OFF_CTRL) || (addr == `CSB_OFF_STATUS) ||
               (addr == `CSB_OFF_PERIOD);
    end
  endfunction

  reg  [`CSB_PIN_W-1:0]   pin_s1_q;
  reg  [`CSB_PIN_W-1:0]   pin_s2_q;
  reg                     ref_prev_q;
  reg                     dclk_prev_q;
  reg  [`CSB_CTRL_W-1:0]  ctrl_q;
  reg  [`CSB_CNT_W-1:0]   per_cnt_q;
  reg  [`CSB_CNT_W-1:0]   period_q;
  reg  [`CSB_CNT_W-1:0]   acc_q;
  reg  [`CSB_PTR_W-1:0]   wr_ptr_q;
  reg  [`CSB_PTR_W-1:0]   rd_ptr_q;
  reg  [`CSB_PTR_W-1:0]   wr_ptr_d;
  reg  [`CSB_PTR_W-1:0]   rd_ptr_d;
  reg  [`CSB_DATA_W-1:0]  data_q;
  reg                     empty_q;
  reg                     full_q;
  reg                     aw_hold_q;
  reg  [`CSB_ADDR_W-1:0]  awaddr_q;
  reg                     w_hold_q;
  reg  [`CSB_BUS_W-1:0]   wdata_q;
  reg  [`CSB_STRB_W-1:0]  wstrb_q;
  reg                     bvalid_q;
  reg  [1:0]              bresp_q;
  reg                     rvalid_q;
  reg  [`CSB_BUS_W-1:0]   rdata_q;
  reg  [1:0]              rresp_q;
  reg  [`CSB_BUS_W-1:0]   rdata_d;

  wire                    ref_s;
  wire                    wen_s;
  wire                    dclk_s;
  wire                    den_s;
  wire [`CSB_DATA_W-1:0]  sample_s;
  wire                    chip_sleep;
  wire                    converter_sleep;
  wire                    auto_halt_on_full;
  wire                    buf_en;
  wire                    pll_en;
  wire                    out_en;
  wire [`CSB_PTR_W-1:0]   depth;
  wire [`CSB_FAC_W-1:0]   factor;
  wire                    ref_rise;
  wire                    drain_rise;
  wire [`CSB_CNT_W-1:0]   acc_sum;
  wire                    pll_tick;
  wire                    sample_tick;
  wire [`CSB_PTR_W-1:0]   count;
  wire                    is_full;
  wire                    do_wr;
  wire                    do_drop;
  wire                    do_rd;
  wire [`CSB_DATA_W-1:0]  ram_rdata;
  wire                    wr_go;

  // Two-stage synchronisers for every pin from outside the core clock
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pin_s1_q <= {`CSB_PIN_W{1'b0}};
      pin_s2_q <= {`CSB_PIN_W{1'b0}};
    end else begin
      pin_s1_q <= {sample_data, drain_en, drain_clk, capture_wen, sample_ref_clk};
      pin_s2_q <= pin_s1_q;
    end
  end

  assign ref_s    = pin_s2_q[`CSB_PIN_REF];
  assign wen_s    = pin_s2_q[`CSB_PIN_WEN];
  assign dclk_s   = pin_s2_q[`CSB_PIN_DCLK];
  assign den_s    = pin_s2_q[`CSB_PIN_DEN];
  assign sample_s = pin_s2_q[`CSB_PIN_DATA_LO +: `CSB_DATA_W];

  // Edge history of the synchronised clocks
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ref_prev_q  <= 1'b0;
      dclk_prev_q <= 1'b0;
    end else begin
      ref_prev_q  <= ref_s;
      dclk_prev_q <= dclk_s;
    end
  end

  assign ref_rise   = ref_s & ~ref_prev_q;
  assign drain_rise = dclk_s & ~dclk_prev_q;

  // Control field breakout
  assign chip_sleep        = ctrl_q[`CSB_B_CHIP_SLEEP];
  assign converter_sleep   = ctrl_q[`CSB_B_CONV_SLEEP];
  assign auto_halt_on_full = ctrl_q[`CSB_B_AUTO_HALT];
  assign buf_en            = ctrl_q[`CSB_B_BUF_EN];
  assign pll_en            = ctrl_q[`CSB_B_PLL_EN];
  assign out_en            = ctrl_q[`CSB_B_OUT_EN];
  assign depth  = depth_of(ctrl_q[`CSB_F_DEPTH_HI:`CSB_F_DEPTH_LO]);
  assign factor = factor_of(ctrl_q[`CSB_F_FACTOR_HI:`CSB_F_FACTOR_LO]);

  // Reference period measured in core cycles, saturating
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      per_cnt_q <= `CSB_CNT_ZERO;
      period_q  <= `CSB_CNT_ZERO;
    end else if (ref_rise) begin
      per_cnt_q <= `CSB_CNT_ZERO;
      period_q  <= (per_cnt_q == `CSB_CNT_MAX) ? per_cnt_q : per_cnt_q + `CSB_CNT_ONE;
    end else if (per_cnt_q != `CSB_CNT_MAX) begin
      per_cnt_q <= per_cnt_q + `CSB_CNT_ONE;
    end
  end

  // Rate accumulator spreads factor-1 ticks over one reference period
  assign acc_sum  = acc_q + {{(`CSB_CNT_W-`CSB_FAC_W){1'b0}}, factor};
  assign pll_tick = (period_q != `CSB_CNT_ZERO) && (acc_sum >= period_q) && !ref_rise;

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      acc_q <= `CSB_CNT_ZERO;
    end else if (ref_rise || !pll_en) begin
      acc_q <= `CSB_CNT_ZERO;
    end else if (pll_tick) begin
      acc_q <= acc_sum - period_q;
    end else begin
      acc_q <= acc_sum;
    end
  end

  // Sample clock: input edge in bypass, multiplied ticks otherwise
  assign sample_tick = (pll_en ? (ref_rise | pll_tick) : ref_rise)
                       & ~converter_sleep & ~chip_sleep;

  // Buffer occupancy and write/read decisions
  assign count   = wr_ptr_q - rd_ptr_q;
  assign is_full = (count >= depth);
  assign do_wr   = sample_tick & wen_s & buf_en
                   & ~(auto_halt_on_full & is_full);
  assign do_drop = do_wr & is_full;
  assign do_rd   = drain_rise & den_s & buf_en & ~chip_sleep
                   & (count != `CSB_PTR_ZERO);

  // Next pointers; a full ring without auto halt drops the oldest byte
  always @* begin
    wr_ptr_d = wr_ptr_q;
    rd_ptr_d = rd_ptr_q;
    if (chip_sleep) begin
      wr_ptr_d = `CSB_PTR_ZERO;
      rd_ptr_d = `CSB_PTR_ZERO;
    end else begin
      if (do_wr) begin
        wr_ptr_d = wr_ptr_q + `CSB_PTR_ONE;
      end
      if (do_rd || do_drop) begin
        rd_ptr_d = rd_ptr_q + `CSB_PTR_ONE;
      end
    end
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_ptr_q <= `CSB_PTR_ZERO;
      rd_ptr_q <= `CSB_PTR_ZERO;
    end else begin
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
    end
  end

  // Byte storage, addressed by the low pointer bits
  csb_byte_ram u_ram (
    .core_clk (core_clk),
    .wr_en    (do_wr),
    .wr_addr  (wr_ptr_q[`CSB_RAM_AW-1:0]),
    .wr_data  (sample_s),
    .rd_addr  (rd_ptr_q[`CSB_RAM_AW-1:0]),
    .rd_data  (ram_rdata)
  );

  // Output byte: drained byte, or live sample when buffer is off
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      data_q <= {`CSB_DATA_W{1'b0}};
    end else if (chip_sleep) begin
      data_q <= data_q;
    end else if (do_rd) begin
      data_q <= ram_rdata;
    end else if (!buf_en && sample_tick) begin
      data_q <= sample_s;
    end
  end

  // Empty flag moves on drain edges; full flag follows occupancy
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      empty_q <= 1'b1;
      full_q  <= 1'b0;
    end else begin
      if (chip_sleep) begin
        empty_q <= 1'b1;
      end else if (drain_rise) begin
        empty_q <= (wr_ptr_d == rd_ptr_d);
      end
      full_q <= ((wr_ptr_d - rd_ptr_d) >= depth);
    end
  end

  assign data_out   = data_q;
  assign data_oe_n  = ~out_en;
  assign empty_flag = empty_q;
  assign full_flag  = full_q;

  // Write channel: address and data taken in either order
  assign s_axi_awready = ~aw_hold_q & ~bvalid_q;
  assign s_axi_wready  = ~w_hold_q & ~bvalid_q;
  assign wr_go         = aw_hold_q & w_hold_q & ~bvalid_q;

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      aw_hold_q <= 1'b0;
      awaddr_q  <= {`CSB_ADDR_W{1'b0}};
      w_hold_q  <= 1'b0;
      wdata_q   <= {`CSB_BUS_W{1'b0}};
      wstrb_q   <= {`CSB_STRB_W{1'b0}};
      bvalid_q  <= 1'b0;
      bresp_q   <= `CSB_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_hold_q <= 1'b0;
        w_hold_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= mapped(awaddr_q) ? `CSB_RESP_OKAY : `CSB_RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;

  // Control register, byte lanes honoured
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= `CSB_CTRL_RST;
    end else if (wr_go && (awaddr_q == `CSB_OFF_CTRL)) begin
      if (wstrb_q[0]) begin
        ctrl_q[`CSB_BYTE0_HI:0] <= wdata_q[`CSB_BYTE0_HI:0];
      end
      if (wstrb_q[1]) begin
        ctrl_q[`CSB_CTRL_HI:`CSB_BYTE0_HI+1] <= wdata_q[`CSB_CTRL_HI:`CSB_BYTE0_HI+1];
      end
    end
  end

  // Read data mux
  always @* begin
    rdata_d = {`CSB_BUS_W{1'b0}};
    case (s_axi_araddr)
      `CSB_OFF_CTRL: begin
        rdata_d[`CSB_CTRL_W-1:0] = ctrl_q;
      end
      `CSB_OFF_STATUS: begin
        rdata_d[`CSB_S_EMPTY]                     = empty_q;
        rdata_d[`CSB_S_FULL]                      = full_q;
        rdata_d[`CSB_S_ASLEEP]                    = chip_sleep;
        rdata_d[`CSB_S_COUNT_LO +: `CSB_PTR_W]    = count;
      end
      `CSB_OFF_PERIOD: begin
        rdata_d[`CSB_CNT_W-1:0] = period_q;
      end
      default: begin
        rdata_d = {`CSB_BUS_W{1'b0}};
      end
    endcase
  end

  // Read channel: one outstanding read, answer the cycle after
  assign s_axi_arready = ~rvalid_q;

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rvalid_q <= 1'b0;
      rdata_q  <= {`CSB_BUS_W{1'b0}};
      rresp_q  <= `CSB_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rdata_d;
      rresp_q  <= mapped(s_axi_araddr) ? `CSB_RESP_OKAY : `CSB_RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata  = rdata_q;
  assign s_axi_rresp  = rresp_q;

endmodule
`default_nettype wire

// ==== testbench/csb_capture_buffer_assertions.sv ====
// Port assertions for the capture buffer
`timescale 1ns/1ns
`default_nettype none
`include "csb_map.vh"

module csb_capture_buffer_chk (
  input wire logic                   core_clk,
  input wire logic                   rst,
  input wire logic                   s_axi_awvalid,
  input wire logic                   s_axi_awready,
  input wire logic                   s_axi_wvalid,
  input wire logic                   s_axi_wready,
  input wire logic                   s_axi_bvalid,
  input wire logic                   s_axi_bready,
  input wire logic [1:0]             s_axi_bresp,
  input wire logic                   s_axi_arvalid,
  input wire logic                   s_axi_arready,
  input wire logic [`CSB_ADDR_W-1:0] s_axi_araddr,
  input wire logic                   s_axi_rvalid,
  input wire logic                   s_axi_rready,
  input wire logic [`CSB_BUS_W-1:0]  s_axi_rdata,
  input wire logic [1:0]             s_axi_rresp,
  input wire logic                   capture_wen,
  input wire logic                   drain_clk,
  input wire logic                   data_oe_n,
  input wire logic                   empty_flag,
  input wire logic                   full_flag
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // Address and data taken together
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence

  // Read taken at an unmapped offset
  sequence s_rd_unmapped;
    s_axi_arvalid && s_axi_arready && (s_axi_araddr >= 12'h00C);
  endsequence

  // Bus answers and holds
  a_write_answer: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  a_unmapped_err: assert property (s_rd_unmapped |=>
    s_axi_rresp == `CSB_RESP_SLVERR && s_axi_rdata == 32'h0) else $error("no error");

  // Pin flags tied to their causes
  a_oe_by_write: assert property ($changed(data_oe_n) |-> $rose(s_axi_bvalid))
    else $error("pin enable moved without a write");
  a_empty_on_drain: assert property ($fell(empty_flag) |->
    $past(drain_clk) || $past(drain_clk, 2) || $past(drain_clk, 3))
    else $error("empty flag fell off a drain edge");
  a_full_on_write: assert property ($rose(full_flag) |->
    $past(capture_wen) || $past(capture_wen, 2) || s_axi_bvalid || $past(s_axi_bvalid))
    else $error("full flag rose without a write");
endmodule

bind csb_capture_buffer csb_capture_buffer_chk csb_capture_buffer_chk_inst (
  .core_clk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
  .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
  .capture_wen, .drain_clk, .data_oe_n, .empty_flag, .full_flag
);
`default_nettype wire

// ==== testbench/csb_drain_reader.sv ====
// Reader model draining captured bytes on its own clock
`timescale 1ns/1ns
`default_nettype none
`include "csb_map.vh"

module csb_drain_reader (
  input  wire logic                   core_clk,
  input  wire logic [`CSB_DATA_W-1:0] data_out,
  output var  logic                   drain_clk,
  output var  logic                   drain_en
);
  logic [`CSB_DATA_W-1:0] got[$];

  // Clock stands low between frames
  initial begin
    drain_clk = 1'b0;
    drain_en = 1'b0;
  end

  // One byte per 160 ns period, optional idle gap; changes right after core edges
  task automatic drain(input int n, input bit slow);
    for (int i = 0; i < n; i++) begin
      drain_en <= 1'b1;         // Raised while clock low
      repeat (4) @(posedge core_clk);
      drain_clk <= 1'b1;
      repeat (4) @(posedge core_clk);
      drain_clk <= 1'b0;
      got.push_back(data_out);
      if (slow) begin
        drain_en <= 1'b0;
        repeat (16) @(posedge core_clk);
      end
    end
    drain_en <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== testbench/csb_testbench.sv ====
// Self-checking bench for the sample capture buffer
`timescale 1ns/1ns
`default_nettype none
`include "csb_map.vh"

module testbench;
  logic                   core_clk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic                   s_axi_arvalid, s_axi_rready, sample_ref_clk, capture_wen;
  logic                   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic                   s_axi_rvalid, data_oe_n, empty_flag, full_flag, drain_clk, drain_en;
  logic [`CSB_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [`CSB_BUS_W-1:0]  s_axi_wdata, s_axi_rdata, d;
  logic [`CSB_STRB_W-1:0] s_axi_wstrb;
  logic [1:0]             s_axi_bresp, s_axi_rresp, r;
  logic [`CSB_DATA_W-1:0] sample_data, data_out;
  int                     miscompares, checks_done, n;

  csb_capture_buffer csb_capture_buffer_inst (
    .core_clk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
    .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .sample_data, .sample_ref_clk, .capture_wen, .drain_clk,
    .drain_en, .data_out, .data_oe_n, .empty_flag, .full_flag
  );
  csb_drain_reader csb_drain_reader_inst (.core_clk, .data_out, .drain_clk, .drain_en);

  // 50 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // Hang guard
  initial begin
    #1000000;
    miscompares++;
    final_report();
  end

  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Bus write, response accepted late
  task automatic axi_wr(input logic [`CSB_ADDR_W-1:0] a, input logic [31:0] v);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
    tick(2);
    s_axi_bready <= 1'b1;
    do @(posedge core_clk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  // Bus read into d and r
  task automatic axi_rd(input logic [`CSB_ADDR_W-1:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge core_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    @(posedge core_clk);
    s_axi_rready <= 1'b1;
    do @(posedge core_clk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // Sleep pulse then new control value
  task automatic flush(input logic [31:0] c);
    axi_wr(`CSB_OFF_CTRL, c | 32'h1);
    axi_wr(`CSB_OFF_CTRL, c);
  endtask

  // Capture n bytes b, b+1, ...
  task automatic cap(input int k, input logic [7:0] b);
    capture_wen <= 1'b1;
    for (int i = 0; i < k; i++) begin
      sample_data <= b + 8'(i);
      tick(4);
      sample_ref_clk <= 1'b1;
      tick(4);
      sample_ref_clk <= 1'b0;
    end
    tick(4);
    capture_wen <= 1'b0;        // Idle before draining
    tick(4);
  endtask

  // Drain k bytes and compare the sequence
  task automatic drn(input int k, input bit slow, input logic [7:0] b);
    csb_drain_reader_inst.drain(k, slow);
    for (int i = 0; i < k; i++) begin
      chk("byte", {24'h0, b + 8'(i)}, {24'h0, csb_drain_reader_inst.got.pop_front()});
    end
    @(posedge core_clk);
  endtask

  // Reference periods of 40 cycles, enable set before each rise
  task automatic ref_run(input int k, input logic w);
    for (int i = 0; i < k; i++) begin
      tick(16);
      capture_wen <= w;
      tick(4);
      sample_ref_clk <= 1'b1;
      tick(20);
      sample_ref_clk <= 1'b0;
    end
  endtask

  task automatic count_chk(input int e);
    axi_rd(`CSB_OFF_STATUS);
    chk("count", 32'(e), (d >> `CSB_S_COUNT_LO) & 32'h7FF);
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Test sequence
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {sample_ref_clk, capture_wen, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_wstrb, sample_data} = '0;
    rst = 1'b1;
    tick(16);
    rst <= 1'b0;
    tick(1);
    axi_rd(`CSB_OFF_CTRL);
    chk("ctrl", 32'h0E8, d);
    chk("flags", 32'h1, {29'h0, data_oe_n, full_flag, empty_flag});
    axi_rd(12'h00C);
    chk("rresp", 32'h2, {30'h0, r});
    axi_wr(12'h00C, 32'hFFFFFFFF);
    chk("bresp", 32'h2, {30'h0, r});
    $display("test reset done");
    cap(6, 8'hFC);
    count_chk(6);
    drn(3, 1'b0, 8'hFC);
    drn(3, 1'b1, 8'hFF);
    chk("empty", 32'h1, {31'h0, empty_flag});
    $display("test order done");
    for (int k = 0; k < 4; k++) begin
      n = 128 << k;
      flush(32'h2C | (k << 6));
      cap(n - 1, 8'h00);
      chk("not full", 32'h0, {31'h0, full_flag});
      cap(2, 8'(n - 1));
      chk("full", 32'h1, {31'h0, full_flag});
      count_chk(n);
      if (k == 0) drn(n, 1'b0, 8'h00);
    end
    $display("test depth done");
    flush(32'h0E8);
    cap(3, 8'h40);
    axi_wr(`CSB_OFF_CTRL, 32'h0EA);
    cap(2, 8'h90);
    drn(2, 1'b0, 8'h40);
    axi_wr(`CSB_OFF_CTRL, 32'h0E9);
    tick(2);
    chk("sleep empty", 32'h1, {31'h0, empty_flag});
    axi_rd(`CSB_OFF_STATUS);
    chk("asleep", 32'h4, d & 32'h4);
    axi_wr(`CSB_OFF_CTRL, 32'h0E8);
    drn(1, 1'b0, 8'h41);
    axi_wr(`CSB_OFF_CTRL, 32'h0C8);
    chk("oe off", 32'h1, {31'h0, data_oe_n});
    axi_wr(`CSB_OFF_CTRL, 32'h0E8);
    chk("oe on", 32'h0, {31'h0, data_oe_n});
    axi_wr(`CSB_OFF_CTRL, 32'h0E0);
    cap(1, 8'h5A);
    chk("live", 32'h5A, {24'h0, data_out});
    $display("test sleep done");
    for (int k = 0; k < 4; k++) begin
      flush(32'h0F8 | (k << 8));
      ref_run(3, 1'b0);
      ref_run(4, 1'b1);
      ref_run(1, 1'b0);
      count_chk(4 * (k + 2));
    end
    axi_rd(`CSB_OFF_PERIOD);
    chk("period", 32'h28, d & 32'hFFFF);
    $display("test multiplier done");
    final_report();
  end
endmodule
`default_nettype wire
